//--- verilog/scr_params.svh
// Offsets, field positions, commands and counts of the register select block
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// Extra bus cycles the internal reset stays on after its cause ends
`define SCR_STRETCH_CYC      4
// Access recovery time added to the stretch of a full software reset
`define SCR_RECOVERY_CYC     2

// Register slots, point-high bit included
`define SCR_SLOT_CMD         4'h0
`define SCR_SLOT_SHARED2     4'h2
`define SCR_SLOT_WR3         4'h3
`define SCR_SLOT_WR4         4'h4
`define SCR_SLOT_WR5         4'h5
`define SCR_SLOT_RR6         4'h6
`define SCR_SLOT_SYNC        4'h7
`define SCR_SLOT_DATA        4'h8
`define SCR_SLOT_MASTER      4'h9
`define SCR_SLOT_WR10        4'hA
`define SCR_SLOT_RB11        4'hB
`define SCR_SLOT_RB14        4'hE
`define SCR_SLOT_ENH         4'hF

// Command register fields
`define SCR_PTR_LSB          0
`define SCR_PTR_MSB          2
`define SCR_CMDCODE_LSB      3
`define SCR_CMDCODE_MSB      5
`define SCR_POINT_HIGH       3'h1

// Master control register fields
`define SCR_RSTCMD_LSB       6
`define SCR_RSTCMD_MSB       7
`define SCR_MASTER_KEEP      8'h3F

// Enhancement control bits
`define SCR_ENH_OPTS_BIT     0
`define SCR_ENH_FIFO_BIT     2

// Enhancement options register
`define SCR_OPT_EXTREAD_BIT  6
`define SCR_OPT_WMASK        8'h7F

// Bits kept by a channel reset in the registers that it touches
`define SCR_CHRST_KEEP3      8'hFE
`define SCR_CHRST_KEEP5      8'h61
`define SCR_RESET_VAL        8'h00

`endif

//--- verilog/scr_pkg.sv
// Types shared by the register select block
package scr_pkg;
    typedef logic [3:0] scr_slot_t;

    // Software reset commands in the master control register
    typedef enum logic [1:0] {
        SCR_RST_NONE = 2'h0,
        SCR_RST_CHB  = 2'h1,
        SCR_RST_CHA  = 2'h2,
        SCR_RST_FULL = 2'h3
    } scr_rstcmd_t;
endpackage : scr_pkg

//--- verilog/scr_reset_stretch.sv
// Internal reset stretcher: holds reset on a set number of cycles after cause
`include "scr_params.svh"
module scr_reset_stretch #(
    parameter int STRETCH  = `SCR_STRETCH_CYC,
    parameter int RECOVERY = `SCR_RECOVERY_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Causes
    input  wire logic hold,
    input  wire logic softLoad,
    // Result
    output logic      active
);
    localparam int CW = $clog2(STRETCH + RECOVERY + 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    // Counts the counter cannot serve are refused at elaboration
    if (STRETCH < 1 || RECOVERY < 0) begin : gBadCounts
        $error("scr_reset_stretch: bad stretch counts");
    end

    // Hold reloads the count so the stretch starts at the release
    always_comb begin
        next_count = count;
        if (hold) begin
            next_count = CW'(STRETCH);
        end else if (softLoad) begin
            next_count = CW'(STRETCH + RECOVERY);
        end else if (count != '0) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign active = hold || (count != '0);
endmodule : scr_reset_stretch

//--- verilog/scr_regmap.sv
// Register pointer, write register bank, read-back map and reset logic
`include "scr_params.svh"
module scr_regmap (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Host bus strobes and selects
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic       ceN,
    input  wire logic       dataCmd,
    input  wire logic       chanA,
    // Host data bus, two-way
    input  wire logic [7:0] dataIn,
    output logic      [7:0] dataOut,
    output logic            dataOeN,
    // Read registers supplied by the channel logic
    output scr_pkg::scr_slot_t readSlot,
    output logic            readChanA,
    input  wire logic [7:0] readStatus,
    // Reset and mode outputs
    output logic            intReset,
    output logic            chanResetA,
    output logic            chanResetB,
    output logic            fifoDeepA,
    output logic            fifoDeepB
);
    // Write registers, both channels; index is {channel, slot}
    logic [7:0] wrReg      [0:31];
    logic [7:0] next_wrReg [0:31];
    logic [7:0] optReg      [0:1];
    logic [7:0] next_optReg [0:1];
    logic [2:0] ptr;
    logic [2:0] next_ptr;
    logic       ptHigh;
    logic       next_ptHigh;
    logic       keepMaster;
    logic       next_keepMaster;
    logic       prevRd;
    logic       prevWr;
    logic       readActive;
    logic       next_readActive;
    logic [7:0] next_dataOut;
    logic       next_chanResetA;
    logic       next_chanResetB;
    logic       fullLoad;

    logic               bothLow;
    logic               rdTake;
    logic               wrTake;
    scr_pkg::scr_slot_t slot;
    logic               ch;
    logic               enhOpts;
    logic               enhFifo;
    logic               extRead;
    logic [7:0]         readValue;
    scr_pkg::scr_rstcmd_t rstCmd;

    // Both strobes low is a reset whatever chip select says
    assign bothLow = !rdN && !wrN;

    // A strobe is taken on its falling edge, never during internal reset
    assign rdTake = !rdN && prevRd && wrN && !ceN && !intReset;
    assign wrTake = !wrN && prevWr && rdN && !ceN && !intReset;

    // Data accesses go to the data slot; command ones use the pointer
    assign ch   = chanA;
    assign slot = dataCmd ? `SCR_SLOT_DATA : {ptHigh, ptr};

    assign enhOpts = wrReg[{ch, `SCR_SLOT_ENH}][`SCR_ENH_OPTS_BIT];
    assign enhFifo = wrReg[{ch, `SCR_SLOT_ENH}][`SCR_ENH_FIFO_BIT];
    assign extRead = enhOpts && optReg[ch][`SCR_OPT_EXTREAD_BIT];
    assign rstCmd  = scr_pkg::scr_rstcmd_t'(
        dataIn[`SCR_RSTCMD_MSB:`SCR_RSTCMD_LSB]);
    assign fifoDeepA = wrReg[{1'b1, `SCR_SLOT_ENH}][`SCR_ENH_FIFO_BIT];
    assign fifoDeepB = wrReg[{1'b0, `SCR_SLOT_ENH}][`SCR_ENH_FIFO_BIT];
    assign fullLoad  = wrTake && !dataCmd && slot == `SCR_SLOT_MASTER
                       && rstCmd == scr_pkg::SCR_RST_FULL;

    // Slots 6 and 7 alias 2 and 3 unless both enhancements are on
    always_comb begin
        readChanA = chanA;
        readSlot  = slot;
        if (!(enhFifo && enhOpts) && (slot == `SCR_SLOT_RR6
                || slot == `SCR_SLOT_SYNC)) begin
            readSlot = slot - 4'h4;
        end
    end

    // Hidden write registers replace the status read when extended
    always_comb begin
        readValue = readStatus;
        if (extRead) begin
            if (slot == `SCR_SLOT_WR4 || slot == `SCR_SLOT_WR5) begin
                readValue = wrReg[{ch, slot}];
            end else if (slot == `SCR_SLOT_MASTER) begin
                readValue = wrReg[{ch, `SCR_SLOT_WR3}];
            end else if (slot == `SCR_SLOT_RB11) begin
                readValue = wrReg[{ch, `SCR_SLOT_WR10}];
            end else if (slot == `SCR_SLOT_RB14) begin
                readValue = optReg[ch];
            end
        end
    end

    // Stretched internal reset; the receive FIFO has no flush from here
    scr_reset_stretch #(
        .STRETCH  (`SCR_STRETCH_CYC),
        .RECOVERY (`SCR_RECOVERY_CYC)
    ) uStretch (
        .clk      (clk),
        .nrst     (nrst),
        .hold     (bothLow),
        .softLoad (fullLoad),
        .active   (intReset)
    );

    // Next state of pointer, register bank and read path
    always_comb begin
        next_wrReg      = wrReg;
        next_optReg     = optReg;
        next_ptr        = ptr;
        next_ptHigh     = ptHigh;
        next_keepMaster = keepMaster && !bothLow;
        next_readActive = readActive && !rdN && !intReset;
        next_dataOut    = dataOut;
        next_chanResetA = 1'b0;
        next_chanResetB = 1'b0;
        if (intReset) begin
            // Master control survives a software full reset only
            for (int i = 0; i < 32; i++) begin
                if (!(keepMaster && i == `SCR_SLOT_MASTER)) begin
                    next_wrReg[i] = `SCR_RESET_VAL;
                end
            end
            next_optReg[0] = `SCR_RESET_VAL;
            next_optReg[1] = `SCR_RESET_VAL;
            next_ptr       = 3'h0;
            next_ptHigh    = 1'b0;
        end else if (wrTake) begin
            if (!dataCmd) begin
                next_ptr    = 3'h0;
                next_ptHigh = 1'b0;
            end
            if (slot == `SCR_SLOT_CMD) begin
                next_wrReg[{ch, slot}] = dataIn;
                next_ptr    = dataIn[`SCR_PTR_MSB:`SCR_PTR_LSB];
                next_ptHigh = dataIn[`SCR_CMDCODE_MSB:`SCR_CMDCODE_LSB]
                              == `SCR_POINT_HIGH;
            end else if (slot == `SCR_SLOT_SYNC && enhOpts) begin
                next_optReg[ch] = dataIn & `SCR_OPT_WMASK;
            end else if (slot == `SCR_SLOT_SHARED2) begin
                next_wrReg[{1'b0, slot}] = dataIn;
            end else if (slot == `SCR_SLOT_MASTER) begin
                // Shared by both channels; command bits are not stored
                next_wrReg[{1'b0, slot}] = dataIn & `SCR_MASTER_KEEP;
                if (rstCmd == scr_pkg::SCR_RST_FULL) begin
                    next_keepMaster = 1'b1;
                end else if (rstCmd != scr_pkg::SCR_RST_NONE) begin
                    // Channel reset touches only its own channel
                    next_wrReg[{rstCmd[1], `SCR_SLOT_CMD}] =
                        `SCR_RESET_VAL;
                    next_wrReg[{rstCmd[1], 4'h1}] = `SCR_RESET_VAL;
                    next_wrReg[{rstCmd[1], `SCR_SLOT_WR3}] =
                        wrReg[{rstCmd[1], `SCR_SLOT_WR3}]
                        & `SCR_CHRST_KEEP3;
                    next_wrReg[{rstCmd[1], `SCR_SLOT_WR5}] =
                        wrReg[{rstCmd[1], `SCR_SLOT_WR5}]
                        & `SCR_CHRST_KEEP5;
                    next_chanResetA = rstCmd == scr_pkg::SCR_RST_CHA;
                    next_chanResetB = rstCmd == scr_pkg::SCR_RST_CHB;
                end
            end else begin
                next_wrReg[{ch, slot}] = dataIn;
            end
        end else if (rdTake) begin
            next_readActive = 1'b1;
            next_dataOut    = readValue;
            if (!dataCmd) begin
                next_ptr    = 3'h0;
                next_ptHigh = 1'b0;
            end
        end
    end

    // Register stage; strobes reset to high so one already low at start is seen as an edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                wrReg[i] <= `SCR_RESET_VAL;
            end
            optReg[0]  <= `SCR_RESET_VAL;
            optReg[1]  <= `SCR_RESET_VAL;
            ptr        <= 3'h0;
            ptHigh     <= 1'b0;
            keepMaster <= 1'b0;
            prevRd     <= 1'b1;
            prevWr     <= 1'b1;
            readActive <= 1'b0;
            dataOut    <= `SCR_RESET_VAL;
            chanResetA <= 1'b0;
            chanResetB <= 1'b0;
        end else begin
            wrReg      <= next_wrReg;
            optReg     <= next_optReg;
            ptr        <= next_ptr;
            ptHigh     <= next_ptHigh;
            keepMaster <= next_keepMaster;
            prevRd     <= rdN;
            prevWr     <= wrN;
            readActive <= next_readActive;
            dataOut    <= next_dataOut;
            chanResetA <= next_chanResetA;
            chanResetB <= next_chanResetB;
        end
    end

    // Bus is driven only while a taken read strobe is still low
    assign dataOeN = !(readActive && !rdN);

    // Checks on reset, pointer and read-back behaviour
    logic [7:0] viewWr3;
    assign viewWr3 = wrReg[{ch, `SCR_SLOT_WR3}];

    sequence strobesRelease;
        bothLow ##1 !bothLow;
    endsequence

    sequence releaseQuiet;
        strobesRelease ##1 (!bothLow && !fullLoad) [*4];
    endsequence

    hw_reset_seen_a: assert property (@(posedge clk) disable iff (!nrst)
        bothLow |-> intReset && !rdTake && !wrTake)
        else $error("reset not recognised while strobes low");

    stretch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        strobesRelease |-> intReset [*4])
        else $error("internal reset ended before four cycles");

    stretch_end_a: assert property (@(posedge clk) disable iff (!nrst)
        releaseQuiet |-> !intReset)
        else $error("internal reset held past five cycles");

    access_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
        intReset && !wrN && $past(wrN) |=> ptr == 3'h0 && !ptHigh)
        else $error("write taken during internal reset");

    ptr_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        rdTake && !dataCmd |=> ptr == 3'h0 && !ptHigh)
        else $error("command read left pointer set");

    opt_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wrTake && !dataCmd && slot == `SCR_SLOT_SYNC && enhOpts && ch
        |=> optReg[1] == ($past(dataIn) & `SCR_OPT_WMASK))
        else $error("options register not written");

    ext_read_a: assert property (@(posedge clk) disable iff (!nrst)
        rdTake && extRead && slot == `SCR_SLOT_MASTER
        |=> dataOut == $past(viewWr3) && !dataOeN)
        else $error("slot nine did not return register three");

    full_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        fullLoad |=> intReset [*6])
        else $error("full software reset too short");

    chan_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        wrTake && !dataCmd && slot == `SCR_SLOT_MASTER
        && rstCmd == scr_pkg::SCR_RST_CHA
        |=> chanResetA && !chanResetB && !intReset
            && wrReg[{1'b1, 4'h1}] == `SCR_RESET_VAL)
        else $error("channel reset wrong");

    master_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        fullLoad ##1 !bothLow [*7]
        |-> wrReg[`SCR_SLOT_MASTER] == ($past(dataIn, 7)
            & `SCR_MASTER_KEEP))
        else $error("master bits lost by full reset");

    alias_map_a: assert property (@(posedge clk) disable iff (!nrst)
        !(enhOpts && enhFifo) && slot == `SCR_SLOT_RR6
        |-> readSlot == 4'h2)
        else $error("slot six not aliased");
endmodule : scr_regmap

//--- bench/scr_chan_model.sv
// Channel logic stand-in that answers the ordinary read register lookups
module scr_chan_model (
    // Lookup from the register select block
    input  wire scr_pkg::scr_slot_t readSlot,
    input  wire logic               readChanA,
    // Value of the selected read register
    output logic [7:0]              readStatus
);
    timeunit 1ns;
    timeprecision 100ps;

    // Channel and slot coded into the value, so a wrong slot shows at once
    assign readStatus = {readChanA, 3'h5, readSlot};
endmodule : scr_chan_model

//--- bench/tb.sv
// Self-checking testbench of the register select and reset block
`include "scr_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic               clk, nrst, rdN, wrN, ceN, dataCmd, chanA;
    logic [7:0]         dataIn, dataOut, readStatus, v;
    logic               dataOeN, readChanA, intReset;
    logic               chanResetA, chanResetB, fifoDeepA, fifoDeepB;
    scr_pkg::scr_slot_t readSlot;
    int                 errors, cmp_count, n, seenA, seenB;
    logic [3:0]         sl [5] = '{4'h4, 4'h5, 4'h9, 4'hB, 4'hE};
    logic [7:0]         ex [5] = '{8'h44, 8'hFF, 8'hFF, 8'hA5, 8'h40};

    scr_regmap i_dut (.clk(clk), .nrst(nrst), .rdN(rdN), .wrN(wrN),
        .ceN(ceN), .dataCmd(dataCmd), .chanA(chanA), .dataIn(dataIn),
        .dataOut(dataOut), .dataOeN(dataOeN), .readSlot(readSlot),
        .readChanA(readChanA), .readStatus(readStatus),
        .intReset(intReset), .chanResetA(chanResetA),
        .chanResetB(chanResetB), .fifoDeepA(fifoDeepA),
        .fifoDeepB(fifoDeepB));
    scr_chan_model i_chan (.readSlot(readSlot), .readChanA(readChanA),
        .readStatus(readStatus));

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Count channel reset pulses mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (chanResetA === 1'b1) seenA++;
        if (chanResetB === 1'b1) seenB++;
    end

    // What the channel model returns for a plain lookup
    function automatic logic [7:0] mdl(input logic ch, input logic [3:0] s);
        return {ch, 3'h5, s};
    endfunction : mdl

    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // One write cycle; strobes go high again for at least one edge
    task automatic wr(input logic ch, input logic dc, input logic [7:0] d);
        @(negedge clk);
        ceN = 1'b0; dataCmd = dc; chanA = ch; dataIn = d; wrN = 1'b0;
        @(negedge clk);
        wrN = 1'b1; ceN = 1'b1;
    endtask : wr

    // One read cycle; bus drive is checked while the strobe is low
    task automatic rd(input logic ch, input logic dc, output logic [7:0] d);
        @(negedge clk);
        ceN = 1'b0; dataCmd = dc; chanA = ch; rdN = 1'b0;
        @(negedge clk);
        @(negedge clk);
        check("dataOeN low", {7'h0, dataOeN}, 8'h00);
        d = dataOut;
        rdN = 1'b1; ceN = 1'b1;
        #1 check("dataOeN high", {7'h0, dataOeN}, 8'h01);
    endtask : rd

    // Point at a slot, high slots through the point-high code
    task automatic point(input logic ch, input logic [3:0] s);
        if (s[3]) wr(ch, 1'b0, {5'h01, s[2:0]});
        else if (s != 4'h0) wr(ch, 1'b0, {5'h00, s[2:0]});
    endtask : point

    task automatic wreg(input logic ch, input logic [3:0] s,
                        input logic [7:0] d);
        point(ch, s);
        wr(ch, 1'b0, d);
    endtask : wreg

    task automatic rreg(input logic ch, input logic [3:0] s,
                        input logic [7:0] exp);
        point(ch, s);
        rd(ch, 1'b0, v);
        check("readback", v, exp);
    endtask : rreg

    // Both strobes low with the chip deselected
    task automatic hwrst;
        @(negedge clk);
        ceN = 1'b1; rdN = 1'b0; wrN = 1'b0;
        repeat (3) begin
            @(negedge clk);
            check("intReset held", {7'h0, intReset}, 8'h01);
        end
        rdN = 1'b1; wrN = 1'b1;
    endtask : hwrst

    // Cycles of internal reset, waiting briefly for it to start
    task automatic stretch_cnt(output int c);
        int k;
        c = 0;
        k = 0;
        #1;
        while (intReset !== 1'b1 && k < 3) begin
            @(negedge clk); #1 k++;
        end
        while (intReset === 1'b1 && c < 20) begin
            c++; @(negedge clk); #1;
        end
    endtask : stretch_cnt

    task automatic conclude;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Watchdog, far beyond the fewer than two hundred cycles the tests take
    initial begin
        #50us;
        errors++;
        conclude();
    end

    initial begin
        errors = 0; cmp_count = 0; seenA = 0; seenB = 0;
        nrst = 1'b0; rdN = 1'b1; wrN = 1'b1; ceN = 1'b1;
        dataCmd = 1'b0; chanA = 1'b0; dataIn = 8'h00;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        check("intReset idle", {7'h0, intReset}, 8'h00);
        // Power-up pointer clear by a command read
        rd(1'b0, 1'b0, v);
        check("slot zero", v, mdl(1'b0, 4'h0));
        // Channel A: options opened, extended read on
        wreg(1'b1, 4'hF, 8'h01);
        check("fifoDeepA", {7'h0, fifoDeepA}, 8'h00);
        wreg(1'b1, 4'h7, 8'hC0);
        wreg(1'b1, 4'h3, 8'hFF);
        wreg(1'b1, 4'h4, 8'h44);
        wreg(1'b1, 4'h5, 8'hFF);
        wreg(1'b1, 4'hA, 8'hA5);
        // Hidden registers read back; bit 7 of options never stored
        for (int i = 0; i < 5; i++) begin
            rreg(1'b1, sl[i], ex[i]);
        end
        rd(1'b1, 1'b0, v);
        check("pointer cleared", v, mdl(1'b1, 4'h0));
        rreg(1'b1, 4'h6, mdl(1'b1, 4'h2));
        rreg(1'b0, 4'h9, mdl(1'b0, 4'h9));
        // Channel B: both enhancement bits give the combined map
        wreg(1'b0, 4'hF, 8'h05);
        check("fifoDeepB", {7'h0, fifoDeepB}, 8'h01);
        check("fifoDeepA kept", {7'h0, fifoDeepA}, 8'h00);
        rreg(1'b0, 4'h6, mdl(1'b0, 4'h6));
        // Channel resets touch only their own channel
        wreg(1'b1, 4'h9, 8'h40);
        repeat (2) @(negedge clk);
        check("pulse B", 8'(seenB), 8'h01);
        check("no pulse A", 8'(seenA), 8'h00);
        rreg(1'b1, 4'h9, 8'hFF);
        wreg(1'b1, 4'h9, 8'h80);
        repeat (2) @(negedge clk);
        check("pulse A", 8'(seenA), 8'h01);
        rreg(1'b1, 4'h9, 8'hFE);
        rreg(1'b1, 4'h5, 8'h61);
        // Full software reset; low master bits ride along and must stay
        wreg(1'b0, 4'h9, 8'hC5);
        stretch_cnt(n);
        check("full stretch",
              8'(n >= `SCR_RECOVERY_CYC + `SCR_STRETCH_CYC - 1 &&
                 n <= `SCR_RECOVERY_CYC + `SCR_STRETCH_CYC + 1),
              8'h01);
        check("fifoDeepB cleared", {7'h0, fifoDeepB}, 8'h00);
        rreg(1'b1, 4'hB, mdl(1'b1, 4'hB));
        // Hardware reset and its stretch
        wreg(1'b1, 4'hF, 8'h05);
        hwrst();
        stretch_cnt(n);
        check("hw stretch", 8'(n >= 4 && n <= 5), 8'h01);
        check("fifoDeepA cleared", {7'h0, fifoDeepA}, 8'h00);
        // Host flushes stale receive data with a dummy data read
        rd(1'b1, 1'b1, v);
        check("dummy data read", v, mdl(1'b1, 4'h8));
        // A point-high write inside the stretch must be lost
        hwrst();
        wr(1'b1, 1'b0, 8'h0F);
        stretch_cnt(n);
        wr(1'b1, 1'b0, 8'h05);
        repeat (2) @(negedge clk);
        check("access ignored", {7'h0, fifoDeepA}, 8'h00);
        rd(1'b1, 1'b0, v);
        conclude();
    end
endmodule : tb
